/* File: tfp_map.vh */
// constants for the timer flag block
// Contract
// RULE1 - compares checked against counter
// RULE2 - compare writes pass shared high-byte latch
// RULE3 - capture loads counter on pin event
// RULE4 - capture reads use shared high-byte latch
// RULE5 - irq requested when enable, global, flag
// RULE6 - software writes zero to reserved bits
// RULE7 - capture flag on event, or TOP
// RULE8 - flags clear on vector or write one
// RULE9 - compare flag set cycle after match
// RULE10 - forced compare never sets compare flag
// RULE11 - overflow flag follows waveform mode
// RULE12 - shared prescaler, independent clock selects
// RULE13 - prescaler free running, first count varies
// RULE14 - count pin latched then registered
// RULE15 - rising edge select 7, falling 6
// RULE16 - pin edge to count 2.5-3.5 cycles
// RULE17 - software toggles external clock when stable
// RULE18 - external clock below system clock/2.5
// RULE19 - external pin clock is never prescaled
// RULE20 - sync mode holds prescaler reset bit
// RULE21 - prescaler reset bit self clears
// RULE22 - clock select encoding
// RULE23 - prescaler reset restarts divider
`ifndef TFP_MAP_VH
`define TFP_MAP_VH
// register byte offsets on the plain register port
`define TFP_ADDR_CMPA_LO   4'h0
`define TFP_ADDR_CMPA_HI   4'h1
`define TFP_ADDR_CMPB_LO   4'h2
`define TFP_ADDR_CMPB_HI   4'h3
`define TFP_ADDR_CAPT_LO   4'h4
`define TFP_ADDR_CAPT_HI   4'h5
`define TFP_ADDR_IRQ_EN    4'h6
`define TFP_ADDR_IRQ_FLAGS 4'h7
`define TFP_ADDR_PSC_CTRL  4'h8
`define TFP_ADDR_TIMER_CFG 4'h9
// field positions
`define TFP_BIT_CAPT       5
`define TFP_BIT_CMPB       2
`define TFP_BIT_CMPA       1
`define TFP_BIT_OVF        0
`define TFP_BIT_SYNC_MODE  7
`define TFP_BIT_PSC_RESET  0
`define TFP_IRQ_MASK       8'h27
// timer config fields
`define TFP_CFG_CS0_LSB    0
`define TFP_CFG_CS1_LSB    3
`define TFP_CFG_EDGE_BIT   6
// reset values
`define TFP_RST_BYTE       8'h00
`define TFP_RST_WORD       16'h0000
// clock select codes
`define TFP_CS_STOP        3'h0
`define TFP_CS_DIV1        3'h1
`define TFP_CS_DIV8        3'h2
`define TFP_CS_DIV64       3'h3
`define TFP_CS_DIV256      3'h4
`define TFP_CS_DIV1024     3'h5
`define TFP_CS_EXT_FALL    3'h6
`define TFP_CS_EXT_RISE    3'h7
// tap masks on the 10-bit chain
`define TFP_PSC_WIDTH      10
`define TFP_DIV8_MASK      10'h007
`define TFP_DIV64_MASK     10'h03f
`define TFP_DIV256_MASK    10'h0ff
`define TFP_DIV1024_MASK   10'h3ff
`endif

/* File: tfp_prescaler.v */
// shared prescaler, clock selects and pin edge detect
`timescale 1ns/10ps
module tfp_prescaler (
    // clock and reset
    input  wire       clock,
    input  wire       rst,
    // prescaler control
    input  wire       psc_clear,
    // timer clock selects
    input  wire [2:0] clock_select_0,
    input  wire [2:0] clock_select_1,
    // synchronised count pin levels
    input  wire       pin_now_0,
    input  wire       pin_prev_0,
    input  wire       pin_now_1,
    input  wire       pin_prev_1,
    // timer clock pulses
    output reg        timer_clock_pulse_0,
    output reg        timer_clock_pulse_1
);
`include "tfp_map.vh"

    reg [`TFP_PSC_WIDTH-1:0] psc_count; // divider chain

    // tick for one timer from its select code
    function sel_tick;
        input [2:0]                cs;
        input [`TFP_PSC_WIDTH-1:0] cnt;
        input                      now;
        input                      prev;
        begin
            case (cs)
                `TFP_CS_DIV1:     sel_tick = 1'b1;                  // [RULE22]
                `TFP_CS_DIV8:     sel_tick = (cnt & `TFP_DIV8_MASK) == `TFP_DIV8_MASK;
                `TFP_CS_DIV64:    sel_tick = (cnt & `TFP_DIV64_MASK) == `TFP_DIV64_MASK;
                `TFP_CS_DIV256:   sel_tick = (cnt & `TFP_DIV256_MASK) == `TFP_DIV256_MASK;
                `TFP_CS_DIV1024:  sel_tick = cnt == `TFP_DIV1024_MASK; // [RULE12]
                `TFP_CS_EXT_FALL: sel_tick = prev & ~now;           // [RULE15] [RULE19]
                `TFP_CS_EXT_RISE: sel_tick = ~prev & now;           // [RULE15]
                default:          sel_tick = 1'b0;                  // stopped
            endcase
        end
    endfunction

    // divider ignores the selects; only its reset stops it
    always @(posedge clock) begin
        if (rst || psc_clear) begin
            psc_count <= {`TFP_PSC_WIDTH{1'b0}};                    // [RULE23]
        end else begin
            psc_count <= psc_count + 1'b1;                          // [RULE13]
        end
    end

    // shared chain, independent taps; a held reset halts internal ticks only,
    // pin edges are never prescaled so they bypass it
    always @(posedge clock) begin
        if (rst) begin
            timer_clock_pulse_0 <= 1'b0;
            timer_clock_pulse_1 <= 1'b0;
        end else begin
            timer_clock_pulse_0 <= (~psc_clear | (&clock_select_0[2:1])) & // [RULE12]
                                   sel_tick(clock_select_0, psc_count, pin_now_0, pin_prev_0);
            timer_clock_pulse_1 <= (~psc_clear | (&clock_select_1[2:1])) &
                                   sel_tick(clock_select_1, psc_count, pin_now_1, pin_prev_1);
        end
    end
endmodule // tfp_prescaler

/* File: tfp_pin_sync.v */
// count pin synchroniser: latch transparent while clock high, then a register
`timescale 1ns/10ps
module tfp_pin_sync (
    // clock and reset
    input  wire clock,
    input  wire rst,
    // raw pin
    input  wire pin_in,
    // synchronised level and one-cycle-old copy
    output reg  pin_now,
    output reg  pin_prev
);
    reg latch_q; // half-cycle latch stage

    // latch is open in the high phase, so the pin gets half a cycle to settle
    always @* begin
        if (clock) begin
            latch_q = pin_in;                                      // [RULE14]
        end else begin
            latch_q = latch_q;
        end
    end

    // register stage plus the edge detector history; 2.5 to 3.5 cycles overall
    always @(posedge clock) begin
        if (rst) begin
            pin_now  <= 1'b0;
            pin_prev <= 1'b0;
        end else begin
            pin_now  <= latch_q;                                   // [RULE14] [RULE16]
            pin_prev <= pin_now;
        end
    end
endmodule // tfp_pin_sync

/* File: tfp_timer_flags.v */
// 16-bit timer compare, capture, flag, enable and prescaler control registers
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module tfp_timer_flags (
    // clock and reset
    input  wire        clock,
    input  wire        rst,
    // register port
    input  wire [3:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_write,
    input  wire        reg_read,
    output reg  [7:0]  reg_rdata,
    // counter core
    input  wire [15:0] counter_value,
    input  wire        overflow_event,
    input  wire        top_event,
    input  wire        capture_is_top,
    input  wire        force_compare_a,
    input  wire        force_compare_b,
    // capture sources
    input  wire        capture_pin,
    input  wire        comparator_out,
    input  wire        capture_use_comparator,
    // cpu interrupt side
    input  wire        global_irq_enable,
    input  wire        capture_vector_ack,
    input  wire        compare_a_vector_ack,
    input  wire        compare_b_vector_ack,
    input  wire        overflow_vector_ack,
    // external count pins
    input  wire        external_count_pin_0,
    input  wire        external_count_pin_1,
    // timer clock pulses
    output reg         timer_clock_pulse_0,
    output reg         timer_clock_pulse_1,
    // compare match strobes and values
    output reg         compare_a_match,
    output reg         compare_b_match,
    output reg  [15:0] compare_a_out,
    output reg  [15:0] compare_b_out,
    output reg  [15:0] capture_out,
    // interrupt requests
    output reg         capture_irq,
    output reg         compare_a_irq,
    output reg         compare_b_irq,
    output reg         overflow_irq,
    // prescaler state
    output reg         prescaler_held
);
`include "tfp_map.vh"

    // register storage
    reg  [15:0] compare_a_value;      // compare channel a
    reg  [15:0] compare_b_value;      // compare channel b
    reg  [15:0] capture_value;        // captured counter
    reg  [7:0]  high_byte_latch;      // shared high byte holding latch
    reg  [7:0]  timer_irq_enables;    // enable bits
    reg  [7:0]  timer_irq_flags;      // sticky flags
    reg         sync_mode_bit;        // keeps prescaler reset asserted
    reg         prescaler_reset_bit;  // prescaler reset request
    reg  [7:0]  timer_cfg;            // clock selects and capture edge
    reg  [15:0] next_capture;         // capture value after events
    reg  [7:0]  next_flags;           // flags after set and clear
    reg  [7:0]  read_mux;             // read data before register
    reg         capt_prev;            // capture source history
    reg         cmpa_hit;             // match seen on the previous tick
    reg         cmpb_hit;
    wire        pin_now_0;
    wire        pin_prev_0;
    wire        pin_now_1;
    wire        pin_prev_1;
    wire        tick_0;
    wire        tick_1;
    wire        capt_src;
    wire        capt_edge;
    wire        wr_flags;

    // write strobe at one offset
    function wr_at;
        input [3:0] addr;
        input       we;
        input [3:0] target;
        begin
            wr_at = we & (addr == target);
        end
    endfunction

    // pin synchronisers, one per count pin
    tfp_pin_sync u_sync0 (
        .clock    (clock),
        .rst      (rst),
        .pin_in   (external_count_pin_0),
        .pin_now  (pin_now_0),
        .pin_prev (pin_prev_0)
    );
    tfp_pin_sync u_sync1 (
        .clock    (clock),
        .rst      (rst),
        .pin_in   (external_count_pin_1),
        .pin_now  (pin_now_1),
        .pin_prev (pin_prev_1)
    );

    // shared prescaler and clock selection
    tfp_prescaler u_psc (
        .clock               (clock),
        .rst                 (rst),
        .psc_clear           (prescaler_reset_bit),
        .clock_select_0      (timer_cfg[`TFP_CFG_CS0_LSB +: 3]),
        .clock_select_1      (timer_cfg[`TFP_CFG_CS1_LSB +: 3]),
        .pin_now_0           (pin_now_0),
        .pin_prev_0          (pin_prev_0),
        .pin_now_1           (pin_now_1),
        .pin_prev_1          (pin_prev_1),
        .timer_clock_pulse_0 (tick_0),
        .timer_clock_pulse_1 (tick_1)
    );

    // capture source: pin or comparator, edge chosen by config bit
    assign capt_src  = capture_use_comparator ? comparator_out : capture_pin;   // [RULE3]
    assign capt_edge = (capt_src != capt_prev) &&
                       (capt_src == timer_cfg[`TFP_CFG_EDGE_BIT]) && !capture_is_top;
    assign wr_flags  = wr_at(reg_addr, reg_write, `TFP_ADDR_IRQ_FLAGS);

    // capture value: events or software writes
    always @* begin
        next_capture = capture_value;
        if (wr_at(reg_addr, reg_write, `TFP_ADDR_CAPT_LO)) begin
            next_capture = {high_byte_latch, reg_wdata};           // [RULE2]
        end else if (capt_edge) begin
            next_capture = counter_value;                          // [RULE3]
        end
    end

    // flags: hardware set wins over a clear in the same cycle
    always @* begin
        next_flags = timer_irq_flags;
        if (wr_flags) begin
            next_flags = next_flags & ~(reg_wdata & `TFP_IRQ_MASK); // [RULE8]
        end
        if (capture_vector_ack) begin
            next_flags[`TFP_BIT_CAPT] = 1'b0;                      // [RULE8]
        end
        if (compare_a_vector_ack) begin
            next_flags[`TFP_BIT_CMPA] = 1'b0;
        end
        if (compare_b_vector_ack) begin
            next_flags[`TFP_BIT_CMPB] = 1'b0;
        end
        if (overflow_vector_ack) begin
            next_flags[`TFP_BIT_OVF] = 1'b0;
        end
        // capture flag: from the event, or from TOP when capture is TOP
        if (capt_edge || (capture_is_top && top_event)) begin
            next_flags[`TFP_BIT_CAPT] = 1'b1;                      // [RULE7]
        end
        // compare flags one tick after the match
        if (tick_1 && cmpa_hit) begin
            next_flags[`TFP_BIT_CMPA] = 1'b1;                      // [RULE9] [RULE10]
        end
        if (tick_1 && cmpb_hit) begin
            next_flags[`TFP_BIT_CMPB] = 1'b1;                      // [RULE9] [RULE10]
        end
        // overflow_event already follows the waveform mode in the counter core
        if (overflow_event) begin
            next_flags[`TFP_BIT_OVF] = 1'b1;                       // [RULE11]
        end
        next_flags = next_flags & `TFP_IRQ_MASK;
    end

    // register writes, high-byte latch and capture
    always @(posedge clock) begin
        if (rst) begin
            compare_a_value   <= `TFP_RST_WORD;
            compare_b_value   <= `TFP_RST_WORD;
            capture_value     <= `TFP_RST_WORD;
            high_byte_latch   <= `TFP_RST_BYTE;
            timer_irq_enables <= `TFP_RST_BYTE;
            timer_irq_flags   <= `TFP_RST_BYTE;
            timer_cfg         <= `TFP_RST_BYTE;
            capt_prev         <= 1'b0;
        end else begin
            capt_prev       <= capt_src;
            capture_value   <= next_capture;
            timer_irq_flags <= next_flags;
            // high byte writes only park in the latch
            if (wr_at(reg_addr, reg_write, `TFP_ADDR_CMPA_HI) ||
                wr_at(reg_addr, reg_write, `TFP_ADDR_CMPB_HI) ||
                wr_at(reg_addr, reg_write, `TFP_ADDR_CAPT_HI)) begin
                high_byte_latch <= reg_wdata;                      // [RULE2]
            end else if (reg_read && reg_addr == `TFP_ADDR_CAPT_LO) begin
                high_byte_latch <= capture_value[15:8];            // [RULE4]
            end
            // low byte write commits both bytes at once
            if (wr_at(reg_addr, reg_write, `TFP_ADDR_CMPA_LO)) begin
                compare_a_value <= {high_byte_latch, reg_wdata};   // [RULE2]
            end
            if (wr_at(reg_addr, reg_write, `TFP_ADDR_CMPB_LO)) begin
                compare_b_value <= {high_byte_latch, reg_wdata};   // [RULE2]
            end
            // reserved enable bits are not stored, so stray ones do no harm; timer_cfg keeps all eight bits
            if (wr_at(reg_addr, reg_write, `TFP_ADDR_IRQ_EN)) begin
                timer_irq_enables <= reg_wdata & `TFP_IRQ_MASK;    // [RULE6]
            end
            if (wr_at(reg_addr, reg_write, `TFP_ADDR_TIMER_CFG)) begin
                timer_cfg <= reg_wdata;
            end
        end
    end

    // prescaler control register
    always @(posedge clock) begin
        if (rst) begin
            sync_mode_bit       <= 1'b0;
            prescaler_reset_bit <= 1'b0;
        end else if (wr_at(reg_addr, reg_write, `TFP_ADDR_PSC_CTRL)) begin
            sync_mode_bit       <= reg_wdata[`TFP_BIT_SYNC_MODE];
            // clearing the mode bit drops the reset in the same write, unless that write also sets the reset bit
            prescaler_reset_bit <= reg_wdata[`TFP_BIT_SYNC_MODE] &
                                   reg_wdata[`TFP_BIT_PSC_RESET];  // [RULE20]
            if (!reg_wdata[`TFP_BIT_SYNC_MODE] && reg_wdata[`TFP_BIT_PSC_RESET]) begin
                prescaler_reset_bit <= 1'b1;                       // [RULE21]
            end
        end else if (!sync_mode_bit) begin
            prescaler_reset_bit <= 1'b0;                           // [RULE21]
        end
    end

    // compare units on the timer clock
    always @(posedge clock) begin
        if (rst) begin
            cmpa_hit        <= 1'b0;
            cmpb_hit        <= 1'b0;
            compare_a_match <= 1'b0;
            compare_b_match <= 1'b0;
        end else begin
            if (tick_1) begin
                cmpa_hit <= counter_value == compare_a_value;      // [RULE1]
                cmpb_hit <= counter_value == compare_b_value;      // [RULE1]
            end
            // forced strobes never reach the flags
            compare_a_match <= (tick_1 & cmpa_hit) | force_compare_a;   // [RULE10]
            compare_b_match <= (tick_1 & cmpb_hit) | force_compare_b;
        end
    end

    // read mux; capture high byte comes from the latch
    always @* begin
        case (reg_addr)
            `TFP_ADDR_CMPA_LO:   read_mux = compare_a_value[7:0];
            `TFP_ADDR_CMPA_HI:   read_mux = compare_a_value[15:8];
            `TFP_ADDR_CMPB_LO:   read_mux = compare_b_value[7:0];
            `TFP_ADDR_CMPB_HI:   read_mux = compare_b_value[15:8];
            `TFP_ADDR_CAPT_LO:   read_mux = capture_value[7:0];
            `TFP_ADDR_CAPT_HI:   read_mux = high_byte_latch;       // [RULE4]
            `TFP_ADDR_IRQ_EN:    read_mux = timer_irq_enables;
            `TFP_ADDR_IRQ_FLAGS: read_mux = timer_irq_flags;
            `TFP_ADDR_PSC_CTRL:  read_mux = {sync_mode_bit, 6'h00, prescaler_reset_bit};
            `TFP_ADDR_TIMER_CFG: read_mux = timer_cfg;
            default:             read_mux = 8'h00;                 // unmapped reads zero
        endcase
    end

    // registered outputs
    always @(posedge clock) begin
        if (rst) begin
            reg_rdata           <= 8'h00;
            timer_clock_pulse_0 <= 1'b0;
            timer_clock_pulse_1 <= 1'b0;
            compare_a_out       <= `TFP_RST_WORD;
            compare_b_out       <= `TFP_RST_WORD;
            capture_out         <= `TFP_RST_WORD;
            capture_irq         <= 1'b0;
            compare_a_irq       <= 1'b0;
            compare_b_irq       <= 1'b0;
            overflow_irq        <= 1'b0;
            prescaler_held      <= 1'b0;
        end else begin
            reg_rdata           <= reg_read ? read_mux : 8'h00;
            timer_clock_pulse_0 <= tick_0;
            timer_clock_pulse_1 <= tick_1;
            compare_a_out       <= compare_a_value;
            compare_b_out       <= compare_b_value;
            capture_out         <= capture_value;
            // enable, global flag and flag
            capture_irq   <= global_irq_enable & timer_irq_enables[`TFP_BIT_CAPT] &
                             next_flags[`TFP_BIT_CAPT];            // [RULE5]
            compare_a_irq <= global_irq_enable & timer_irq_enables[`TFP_BIT_CMPA] &
                             next_flags[`TFP_BIT_CMPA];            // [RULE5]
            compare_b_irq <= global_irq_enable & timer_irq_enables[`TFP_BIT_CMPB] &
                             next_flags[`TFP_BIT_CMPB];
            overflow_irq  <= global_irq_enable & timer_irq_enables[`TFP_BIT_OVF] &
                             next_flags[`TFP_BIT_OVF];
            prescaler_held <= prescaler_reset_bit;
        end
    end
endmodule // tfp_timer_flags

/* File: tfp_timer_flags_monitor.sv */
// assertions on the timer flag block ports
`timescale 1ns/10ps
module tfp_monitor (
    // clock and reset
    input wire        clock,
    input wire        rst,
    // register port
    input wire [3:0]  reg_addr,
    input wire [7:0]  reg_wdata,
    input wire        reg_write,
    input wire        reg_read,
    input wire [7:0]  reg_rdata,
    // pins and outputs under watch
    input wire        global_irq_enable,
    input wire        external_count_pin_1,
    input wire        timer_clock_pulse_0,
    input wire        timer_clock_pulse_1,
    input wire [15:0] compare_a_out,
    input wire        capture_irq,
    input wire        overflow_irq,
    input wire        prescaler_held
);
    reg [7:0] cfg; // config shadow
    reg [7:0] hi;  // latch shadow
    default clocking dc @(posedge clock); endclocking
    default disable iff (rst);
    // shadows follow writes only
    always @(posedge clock) begin
        if (rst) begin
            cfg <= 8'h00;
            hi <= 8'h00;
        end else if (reg_write) begin
            if (reg_addr == 4'h9)
                cfg <= reg_wdata;
            if (reg_addr[0] && reg_addr < 4'h6)
                hi <= reg_wdata;
        end
    end
    // prescaler control write
    sequence s_psc_write(logic [7:0] d);
        reg_write && reg_addr == 4'h8 && reg_wdata == d;
    endsequence
    // settled div8 tick
    sequence s_div8_tick;
        (cfg[2:0] == 3'h2) [*3] ##0 timer_clock_pulse_0;
    endsequence
    a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("stray read data");
    a_cmpa_commit: assert property (reg_write && reg_addr == 4'h0 |->
        ##2 compare_a_out == {$past(hi, 2), $past(reg_wdata, 2)})
        else $error("compare a commit");
    a_held_pulse: assert property (s_psc_write(8'h01) |->
        ##[1:2] prescaler_held ##1 !prescaler_held)
        else $error("reset not one pulse");
    a_sync_hold: assert property (s_psc_write(8'h81) |-> ##[1:2] prescaler_held [*4])
        else $error("reset not held");
    a_held_stops: assert property (prescaler_held && $past(prescaler_held) &&
        cfg[2:0] >= 3'h2 && cfg[2:0] <= 3'h5 |-> !timer_clock_pulse_0)
        else $error("tick while held");
    a_div1_every: assert property ((cfg[2:0] == 3'h1 && !prescaler_held) [*3]
        |-> timer_clock_pulse_0)
        else $error("missed div1 tick");
    a_div8_gap: assert property (s_div8_tick |=> !timer_clock_pulse_0 [*7])
        else $error("div8 gap short");
    a_ext_rise: assert property ($rose(external_count_pin_1) && cfg[5:3] == 3'h7
        |-> ##[2:4] timer_clock_pulse_1)
        else $error("rise not counted");
    a_ext_fall: assert property ($fell(external_count_pin_1) && cfg[5:3] == 3'h6
        |-> ##[2:4] timer_clock_pulse_1)
        else $error("fall not counted");
    a_irq_global: assert property (capture_irq || overflow_irq |-> $past(global_irq_enable))
        else $error("irq without global");
endmodule // tfp_monitor

/* File: tb_tfp_timer_flags.sv */
// testbench for the timer flag block
`timescale 1ns/10ps
module tb_tfp_timer_flags;
    // stimulus
    reg         clock = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
    reg  [3:0]  reg_addr = 4'h0;
    reg  [3:0]  ack = 4'h0; // vector acks: capt, a, b, ovf
    reg  [7:0]  reg_wdata = 8'h00;
    reg  [15:0] counter_value = 16'h0000;
    reg         overflow_event = 1'b0, force_compare_a = 1'b0, force_compare_b = 1'b0;
    reg         capture_pin = 1'b0, global_irq_enable = 1'b0, external_count_pin_1 = 1'b0;
    // observed outputs
    wire [7:0]  reg_rdata;
    wire [15:0] compare_a_out, compare_b_out, capture_out;
    wire        timer_clock_pulse_0, timer_clock_pulse_1, capture_irq, overflow_irq;
    wire        prescaler_held;
    // ex: timer 0 pulses per 2048 cycles by select
    integer     err_count = 0, n_tests = 0, cyc = 0, p0 = 0, p1 = 0, a0, a1, k;
    integer     ex [0:5] = '{0, 2048, 256, 32, 8, 2};
    reg  [7:0]  lo, hi;
    tfp_timer_flags i_dut (
        .clock, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .counter_value, .overflow_event, .top_event(1'b0), .capture_is_top(1'b0),
        .force_compare_a, .force_compare_b, .capture_pin, .comparator_out(1'b0),
        .capture_use_comparator(1'b0), .global_irq_enable, .capture_vector_ack(ack[3]),
        .compare_a_vector_ack(ack[2]), .compare_b_vector_ack(ack[1]),
        .overflow_vector_ack(ack[0]), .external_count_pin_0(1'b0), .external_count_pin_1,
        .timer_clock_pulse_0, .timer_clock_pulse_1, .compare_a_match(), .compare_b_match(),
        .compare_a_out, .compare_b_out, .capture_out, .capture_irq, .compare_a_irq(),
        .compare_b_irq(), .overflow_irq, .prescaler_held);
    always #12.5 clock = ~clock;
    // pulse tallies and timeout
    always @(posedge clock) begin
        if (!rst) begin
            p0 <= p0 + timer_clock_pulse_0;
            p1 <= p1 + timer_clock_pulse_1;
        end
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            test_done;
        end
    end
    task tick(input integer n);
        begin
            repeat (n) @(posedge clock);
            #1;
        end
    endtask
    // one-cycle write strobe
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge clock);
            reg_addr <= a;
            reg_wdata <= d;
            reg_write <= 1'b1;
            @(posedge clock);
            reg_write <= 1'b0;
        end
    endtask
    // data taken the cycle after the strobe
    task rd(input [3:0] a, output [7:0] d);
        begin
            @(posedge clock);
            reg_addr <= a;
            reg_read <= 1'b1;
            @(posedge clock);
            reg_read <= 1'b0;
            #1 d = reg_rdata;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("[FAIL] %0t: got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task test_done;
        begin
            if (err_count == 0 && n_tests > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        // compare writes commit on low byte
        wr(4'h1, 8'h12);
        wr(4'h0, 8'h34);
        wr(4'h3, 8'hab);
        wr(4'h2, 8'hcd);
        wr(4'h1, 8'h77);
        tick(2);
        chk(compare_a_out, 16'h1234);
        chk(compare_b_out, 16'habcd);
        // rising capture, falling ignored
        wr(4'h9, 8'h40);
        @(posedge clock) counter_value <= 16'h5a3c;
        @(posedge clock) capture_pin <= 1'b1;
        tick(4);
        @(posedge clock) counter_value <= 16'h0001;
        @(posedge clock) capture_pin <= 1'b0;
        tick(4);
        chk(capture_out, 16'h5a3c);
        rd(4'h4, lo);
        rd(4'h5, hi);
        chk({hi, lo}, 16'h5a3c);
        rd(4'h7, lo);
        chk(lo, 8'h20);
        // enables, global gate, clear
        wr(4'h6, 8'h27);
        rd(4'h6, lo);
        chk(lo, 8'h27);
        chk(capture_irq, 1'b0);
        @(posedge clock) global_irq_enable <= 1'b1;
        tick(2);
        chk(capture_irq, 1'b1);
        wr(4'h7, 8'h00);
        rd(4'h7, lo);
        chk(lo, 8'h20);
        wr(4'h7, 8'h20);
        tick(2);
        chk(capture_irq, 1'b0);
        @(posedge clock) global_irq_enable <= 1'b0;
        // force and overflow, then a real match
        @(posedge clock);
        counter_value <= 16'h1234;
        {force_compare_a, force_compare_b, overflow_event} <= 3'h7;
        @(posedge clock);
        {force_compare_a, force_compare_b, overflow_event} <= 3'h0;
        rd(4'h7, lo);
        chk(lo, 8'h01);
        wr(4'h9, 8'h08);
        tick(6);
        rd(4'h7, lo);
        chk(lo, 8'h03);
        wr(4'h9, 8'h00);
        @(posedge clock) counter_value <= 16'h0000;
        @(posedge clock) ack <= 4'hf;
        @(posedge clock) ack <= 4'h0;
        rd(4'h7, lo);
        chk(lo, 8'h00);
        // timer 0 codes, timer 1 at /64
        for (k = 0; k < 6; k = k + 1) begin
            wr(4'h9, 8'h18 | k[7:0]);
            tick(20);
            a0 = p0;
            a1 = p1;
            tick(2048);
            chk(p0 - a0, ex[k]);
            chk(p1 - a1, 32);
        end
        // reset pulse, then sync hold
        wr(4'h9, 8'h02);
        wr(4'h8, 8'h01);
        rd(4'h8, lo);
        chk(lo, 8'h00);
        wr(4'h8, 8'h81);
        tick(3);
        chk(prescaler_held, 1'b1);
        a0 = p0;
        tick(40);
        chk(p0 - a0, 0);
        wr(4'h8, 8'h00);
        a0 = p0;
        tick(5);
        chk(p0 - a0, 0);
        tick(6);
        chk(p0 - a0, 1);
        chk(prescaler_held, 1'b0);
        // pin edges, rising then falling
        for (k = 7; k > 5; k = k - 1) begin
            wr(4'h9, {2'b00, k[2:0], 3'b000});
            tick(4);
            a1 = p1;
            repeat (5) begin
                @(posedge clock) external_count_pin_1 <= 1'b1;
                tick(4);
                @(posedge clock) external_count_pin_1 <= 1'b0;
                tick(4);
            end
            tick(6);
            chk(p1 - a1, 5);
        end
        test_done;
    end
endmodule // tb_tfp_timer_flags
bind tfp_timer_flags tfp_monitor i_mon (
    .clock, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .global_irq_enable, .external_count_pin_1, .timer_clock_pulse_0, .timer_clock_pulse_1,
    .compare_a_out, .capture_irq, .overflow_irq, .prescaler_held);
